/* File: verif/ebu_external_bus_unit_test.sv */
`timescale 1ns/10ps
`include "ebu_map.svh"
module ebu_external_bus_unit_test
	import ebu_pkg::*;
;
	logic		clk_sys = 1'b0;
	logic		rst = 1'b1;
	logic [7:0]	reg_addr = 8'h00;
	logic [15:0]	reg_wdata = 16'h0000;
	logic		reg_wr = 1'b0;
	logic		reg_rd = 1'b0;
	logic		req_valid = 1'b0;
	ebu_req_t	req = '0;
	logic		hold_n = 1'b1;
	logic		hold_ack_pin_n_in = 1'b1;
	logic [3:0]	stall = 4'h0;
	logic [15:0]	reg_rdata, data_port_in, data_port_out, data_port_oe, address_port, q;
	logic [7:0]	seg_addr, seg_addr_oe;
	logic [4:0]	cs_n, cs;
	logic		req_ready, rsp_valid, address_port_oe, ale, rd_n, wr_n, ctrl_oe, ready_n, e;
	logic		hold_ack_pin_n_out, hold_ack_pin_oe, bus_request_pin_n, bus_request_pin_oe;
	ebu_rsp_t	rsp;
	int		err_total = 0;
	int		n_tests = 0;
	int		cyc = 0;
	int		lat;

	ebu_external_bus_unit i_dut (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .req_valid, .req_ready, .req, .rsp_valid, .rsp, .data_port_in,
		.data_port_out, .data_port_oe, .address_port, .address_port_oe, .seg_addr,
		.seg_addr_oe, .ale, .rd_n, .wr_n, .cs_n, .ctrl_oe, .ready_n, .hold_n,
		.hold_ack_pin_n_in, .hold_ack_pin_n_out, .hold_ack_pin_oe, .bus_request_pin_n,
		.bus_request_pin_oe);
	ebu_mem_model i_mem (.clk_sys, .address_port, .address_port_oe, .data_port_out, .ale,
		.rd_n, .wr_n, .stall, .data_port_in, .ready_n);

	initial forever #12.5 clk_sys = ~clk_sys;

	task automatic close_out;
		if (err_total == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : close_out

	// Whole run needs well under a thousand cycles
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			close_out();
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		@(posedge clk_sys);
	endtask : wr

	task automatic rd(input logic [7:0] a);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(posedge clk_sys);
		q = reg_rdata;
	endtask : rd

	task automatic acc(input logic w, input logic [23:0] a, input logic [15:0] d);
		req_valid <= 1'b1;
		req <= '{w, a, d};
		cs = 5'h1f;
		do @(posedge clk_sys); while (req_ready !== 1'b1);
		req_valid <= 1'b0;
		lat = 0;
		do begin
			@(posedge clk_sys);
			lat++;
			if (ale === 1'b1)
				cs = cs_n;
		end while (rsp_valid !== 1'b1);
		q = rsp.rdata;
		e = rsp.err;
	endtask : acc

	task automatic t_regs;
		chk({hold_ack_pin_oe, bus_request_pin_oe}, 2'h0);
		rd(`EBU_OFF_SYSCFG);
		chk(q, 16'h0000);
		rd(`EBU_OFF_STATUS);
		chk(q, 16'h0080);
		wr(8'h3f, 16'hffff);
		rd(8'h3f);
		chk(q, 16'h0000);
		wr(`EBU_OFF_WSEL1, 16'h1234);
		rd(`EBU_OFF_WSEL1);
		chk(q, 16'h1234);
		acc(1'b0, 24'h000100, 16'h0000);
		chk({e, lat[3:0]}, 5'h11);
	endtask : t_regs

	task automatic t_seg;
		logic [7:0] tab [4] = '{8'hff, 8'h0f, 8'h03, 8'h00};
		for (int k = 0; k < 4; k++) begin
			wr(`EBU_OFF_SYSCFG, 16'(k << 1));
			chk(seg_addr_oe, tab[k]);
		end
		wr(`EBU_OFF_SYSCFG, 16'h0002);
	endtask : t_seg

	task automatic t_modes;
		for (int m = 0; m < 4; m++) begin
			wr(`EBU_OFF_BCFG0, 16'(12'hc02 | m << 7));
			acc(1'b1, 24'(64 + m), 16'(16'ha5c3 ^ m));
			chk(lat, 5);
			chk(cs, 5'h1e);
			acc(1'b0, 24'(64 + m), 16'h0000);
			chk(q, 16'((m > 1 ? 16'ha5c3 : 16'h00c3) ^ m));
		end
	endtask : t_modes

	task automatic t_time;
		wr(`EBU_OFF_BCFG0, 16'h0d61);
		acc(1'b1, 24'h000050, 16'h1111);
		chk(lat, 6);
		wr(`EBU_OFF_BCFG0, 16'h0f00);
		stall <= 4'h6;
		acc(1'b1, 24'h000050, 16'h2222);
		chk(lat >= 9 && lat < 20, 1'b1);
		stall <= 4'h0;
	endtask : t_time

	task automatic t_prio;
		for (int i = 1; i <= 4; i++) begin
			wr(8'(`EBU_OFF_BCFG0 + i), 16'h0d00);
			wr(8'(`EBU_OFF_WSEL1 + i - 1), 16'h0100);
			acc(1'b1, 24'h010020, 16'h3333);
			chk(cs, 5'h1f ^ (5'h01 << i));
		end
		chk(seg_addr, 8'h01);
	endtask : t_prio

	task automatic t_hold;
		hold_n <= 1'b0;
		repeat (4) @(posedge clk_sys);
		chk(hold_ack_pin_oe, 1'b0);
		acc(1'b1, 24'h000060, 16'h4444);
		chk(e, 1'b0);
		wr(`EBU_OFF_SYSCFG, 16'h0012);
		repeat (3) @(posedge clk_sys);
		req_valid <= 1'b1;
		req <= '{1'b1, 24'h000060, 16'h5555};
		repeat (2) @(posedge clk_sys);
		chk({hold_ack_pin_oe, hold_ack_pin_n_out, data_port_oe[0], req_ready}, 4'h8);
		chk({bus_request_pin_oe, bus_request_pin_n}, 2'h2);
		hold_n <= 1'b1;
		acc(1'b1, 24'h000060, 16'h5555);
		chk(e, 1'b0);
		wr(`EBU_OFF_PORTDIR, 16'h0080);
		rd(`EBU_OFF_STATUS);
		chk(q, 16'h0060);
		req_valid <= 1'b1;
		req <= '{1'b0, 24'h000060, 16'h0000};
		repeat (4) @(posedge clk_sys);
		chk({hold_ack_pin_oe, req_ready, bus_request_pin_n}, 3'h0);
		hold_ack_pin_n_in <= 1'b0;
		acc(1'b0, 24'h000060, 16'h0000);
		chk(q, 16'h5555);
	endtask : t_hold

	initial begin
		repeat (12) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		t_regs();
		t_seg();
		t_modes();
		t_time();
		t_prio();
		t_hold();
		close_out();
	end
endmodule : ebu_external_bus_unit_test

/* File: verif/ebu_mem_model.sv */
`timescale 1ns/10ps
module ebu_mem_model (
	input logic		clk_sys,
	input logic [15:0]	address_port,
	input logic		address_port_oe,
	input logic [15:0]	data_port_out,
	input logic		ale,
	input logic		rd_n,
	input logic		wr_n,
	input logic [3:0]	stall,
	output logic [15:0]	data_port_in,
	output logic		ready_n
);
	logic [15:0]	mem [0:255];
	logic [7:0]	lat;
	logic [15:0]	last = 16'h0000;
	logic [3:0]	cnt = 4'h0;

	always @(posedge clk_sys) begin
		if (ale)
			lat <= address_port_oe ? address_port[7:0] : data_port_out[7:0];
		if (!wr_n)
			mem[lat] <= data_port_out;
		cnt <= (rd_n && wr_n) ? 4'h0 : cnt + 4'h1;
		last <= ~last;
	end

	// Released bus toggles so a late sample can never match by luck
	assign data_port_in = rd_n ? last : mem[lat];
	// Pull-up outside strobes; ready only after the commanded stall
	assign ready_n = ~((!rd_n || !wr_n) && cnt >= stall);
endmodule : ebu_mem_model

/* File: verif/ebu_properties.sv */
`timescale 1ns/10ps
module ebu_properties
	import ebu_pkg::*;
(
	input logic		clk_sys,
	input logic		rst,
	input logic		ale,
	input logic		rd_n,
	input logic		wr_n,
	input logic [4:0]	cs_n,
	input logic		rsp_valid,
	input ebu_rsp_t		rsp,
	input logic [15:0]	data_port_oe,
	input logic		address_port_oe,
	input logic [7:0]	seg_addr_oe,
	input logic		ctrl_oe,
	input logic		hold_ack_pin_n_out,
	input logic		hold_ack_pin_oe,
	input logic		bus_request_pin_oe
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);

	AST_SEG_SIZE: assert property (seg_addr_oe inside {8'hff, 8'h0f, 8'h03, 8'h00})
		else $error("segment enables off size");
	AST_ALE_LEN: assert property ($rose(ale) |-> ##[1:2] !ale)
		else $error("ale too long");
	AST_ALE_GAP: assert property ($fell(ale) |-> ##[0:1] (!rd_n || !wr_n))
		else $error("strobe late after ale");
	AST_RSP_END: assert property (rsp_valid && !rsp.err |-> $rose(rd_n) || $rose(wr_n))
		else $error("response not at strobe end");
	AST_MUX_ADDR: assert property (ale && !address_port_oe |-> &data_port_oe)
		else $error("mux address not driven");
	AST_RD_FLOAT: assert property (!rd_n |-> data_port_oe == 16'h0000)
		else $error("data driven in read");
	AST_CS_ONE: assert property ($onehot0(~cs_n))
		else $error("two chip selects");
	AST_CS_HOLD: assert property (!rd_n || !wr_n |-> $stable(cs_n))
		else $error("chip select moved in strobe");
	AST_HOLD_FLOAT: assert property (hold_ack_pin_oe && !hold_ack_pin_n_out |->
		!ctrl_oe && data_port_oe == 16'h0000 && !address_port_oe)
		else $error("bus driven while held");
	AST_ACK_EN: assert property (hold_ack_pin_oe |-> bus_request_pin_oe)
		else $error("ack driven without hold enable");
endmodule : ebu_properties

bind ebu_external_bus_unit ebu_properties i_props (.clk_sys, .rst, .ale, .rd_n, .wr_n, .cs_n,
	.rsp_valid, .rsp, .data_port_oe, .address_port_oe, .seg_addr_oe, .ctrl_oe,
	.hold_ack_pin_n_out, .hold_ack_pin_oe, .bus_request_pin_oe);

/* File: verilog/ebu_external_bus_unit.sv */
`timescale 1ns/10ps
`include "ebu_map.svh"

// Functional notes
// - Single-chip or four external bus modes
// - Demux: address port, data full or low
// - Mux: address then data on data port
// - Wait, tri-state, ALE length, strobe delay programmable
// - Four windows, each select plus config
// - Window four beats three, two beats one
// - Outside all windows use default config
// - Five chip selects, four windows plus default
// - Ready input extends slow accesses
// - Arbitration only with hold enable bit
// - Hold enable hands pins to controller
// - Master after reset, acknowledge is output
// - Direction bit one selects slave mode
// - Space limit gives four, two, none segment lines
// - Full space drives all eight segment lines
// - Bus request pin is output only
module ebu_external_bus_unit
	import ebu_pkg::*;
(
	input  logic         clk_sys,
	input  logic         rst,
	input  logic [7:0]   reg_addr,
	input  logic [15:0]  reg_wdata,
	input  logic         reg_wr,
	input  logic         reg_rd,
	output logic [15:0]  reg_rdata,
	input  logic         req_valid,
	output logic         req_ready,
	input  ebu_req_t     req,
	output logic         rsp_valid,
	output ebu_rsp_t     rsp,
	input  logic [15:0]  data_port_in,
	output logic [15:0]  data_port_out,
	output logic [15:0]  data_port_oe,
	output logic [15:0]  address_port,
	output logic         address_port_oe,
	output logic [7:0]   seg_addr,
	output logic [7:0]   seg_addr_oe,
	output logic         ale,
	output logic         rd_n,
	output logic         wr_n,
	output logic [4:0]   cs_n,
	output logic         ctrl_oe,
	input  logic         ready_n,
	input  logic         hold_n,
	input  logic         hold_ack_pin_n_in,
	output logic         hold_ack_pin_n_out,
	output logic         hold_ack_pin_oe,
	output logic         bus_request_pin_n,
	output logic         bus_request_pin_oe
);
	logic [15:0]         system_config_reg;
	logic [15:0]         port_dir_reg;
	ebu_bus_cfg_t        bus_config_reg [0:`EBU_NUM_WIN];
	logic [15:0]         window_select_reg [1:`EBU_NUM_WIN];
	logic [2:0]          meta_ctl;
	logic [2:0]          sync_ctl;
	logic [15:0]         meta_data;
	logic [15:0]         sync_data;
	logic                ready_sync_n;
	logic                hold_sync_n;
	logic                ack_sync_n;
	logic [`EBU_NUM_WIN-1:0] win_hit;
	logic [2:0]          sel_win;
	ebu_bus_cfg_t        sel_cfg;
	ebu_state_t          state;
	ebu_bus_cfg_t        cur_cfg;
	ebu_req_t            cur_req;
	logic [3:0]          cnt;
	logic                data_oe;
	logic                hold_en;
	logic                slave;
	logic                granted;
	logic                floating;
	logic                cur_mux;
	logic                cur_8bit;

	assign hold_en  = system_config_reg[`EBU_SYSCFG_HOLD_ENABLE_BIT];
	assign slave    = port_dir_reg[`EBU_DIR_ACK_BIT];
	assign cur_mux  = (cur_cfg.mode == EBU_MODE_8_MUX) || (cur_cfg.mode == EBU_MODE_16_MUX);
	assign cur_8bit = (cur_cfg.mode == EBU_MODE_8_MUX) || (cur_cfg.mode == EBU_MODE_8_DEMUX);

	// Pins from outside pass two flops before use
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			meta_ctl  <= 3'h7;
			sync_ctl  <= 3'h7;
			meta_data <= 16'h0000;
			sync_data <= 16'h0000;
		end else begin
			meta_ctl  <= {ready_n, hold_n, hold_ack_pin_n_in};
			sync_ctl  <= meta_ctl;
			meta_data <= data_port_in;
			sync_data <= meta_data;
		end
	end

	assign ready_sync_n = sync_ctl[2];
	assign hold_sync_n  = sync_ctl[1];
	assign ack_sync_n   = sync_ctl[0];

	// Register writes
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			system_config_reg <= `EBU_SYSCFG_RST;
			port_dir_reg      <= `EBU_PORTDIR_RST;
			for (int i = 0; i <= `EBU_NUM_WIN; i++) begin
				bus_config_reg[i] <= `EBU_BCFG_RST;
			end
			for (int i = 1; i <= `EBU_NUM_WIN; i++) begin
				window_select_reg[i] <= `EBU_WSEL_RST;
			end
		end else if (reg_wr) begin
			if (reg_addr == `EBU_OFF_SYSCFG) begin
				system_config_reg <= reg_wdata;
			end else if (reg_addr == `EBU_OFF_PORTDIR) begin
				port_dir_reg <= reg_wdata;
			end else begin
				for (int i = 0; i <= `EBU_NUM_WIN; i++) begin
					if (reg_addr == `EBU_OFF_BCFG0 + 8'(i)) begin
						bus_config_reg[i] <= reg_wdata;
					end
				end
				for (int i = 1; i <= `EBU_NUM_WIN; i++) begin
					if (reg_addr == `EBU_OFF_WSEL1 + 8'(i - 1)) begin
						window_select_reg[i] <= reg_wdata;
					end
				end
			end
		end
	end

	// Read data one cycle after the strobe; unmapped reads return zero
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			reg_rdata <= 16'h0000;
			if (reg_addr == `EBU_OFF_SYSCFG) begin
				reg_rdata <= system_config_reg;
			end else if (reg_addr == `EBU_OFF_PORTDIR) begin
				reg_rdata <= port_dir_reg;
			end else if (reg_addr == `EBU_OFF_STATUS) begin
				reg_rdata <= {8'h00, granted, slave, hold_en, 2'(cur_mux), state};
			end else begin
				for (int i = 0; i <= `EBU_NUM_WIN; i++) begin
					if (reg_addr == `EBU_OFF_BCFG0 + 8'(i)) begin
						reg_rdata <= bus_config_reg[i];
					end
				end
				for (int i = 1; i <= `EBU_NUM_WIN; i++) begin
					if (reg_addr == `EBU_OFF_WSEL1 + 8'(i - 1)) begin
						reg_rdata <= window_select_reg[i];
					end
				end
			end
		end
	end

	for (genvar g = 0; g < `EBU_NUM_WIN; g++) begin : g_win
		logic raw_hit;
		ebu_window_match #(
			.ADDR_W (24)
		) u_match (
			.window_select_reg (window_select_reg[g + 1]),
			.addr              (req.addr),
			.hit               (raw_hit)
		);
		// A window whose config is inactive never claims an address
		assign win_hit[g] = raw_hit && bus_config_reg[g + 1].bus_act;
	end

	// Higher window wins where windows overlap
	always_comb begin
		if (win_hit[3]) begin
			sel_win = 3'h4;
		end else if (win_hit[2]) begin
			sel_win = 3'h3;
		end else if (win_hit[1]) begin
			sel_win = 3'h2;
		end else if (win_hit[0]) begin
			sel_win = 3'h1;
		end else begin
			sel_win = 3'h0;
		end
		sel_cfg = bus_config_reg[sel_win];
	end

	// With hold enabled, a slave owns the bus only while the other master acknowledges
	assign granted   = !(hold_en && slave) || !ack_sync_n;
	assign req_ready = req_valid && (state == EBU_ST_IDLE) && granted
		&& !(hold_en && !slave && !hold_sync_n);

	// Access sequencer; pins are registered so they change with state
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state         <= EBU_ST_IDLE;
			cur_cfg       <= `EBU_BCFG_RST;
			cur_req       <= '0;
			cnt           <= 4'h0;
			ale           <= 1'b0;
			rd_n          <= 1'b1;
			wr_n          <= 1'b1;
			cs_n          <= 5'h1f;
			address_port  <= 16'h0000;
			seg_addr      <= 8'h00;
			data_port_out <= 16'h0000;
			data_oe       <= 1'b0;
			rsp_valid     <= 1'b0;
			rsp           <= '0;
		end else begin
			rsp_valid <= 1'b0;
			case (state)
				EBU_ST_IDLE: begin
					cs_n <= 5'h1f;
					if (hold_en && !slave && !hold_sync_n) begin
						state <= EBU_ST_HELD;
					end else if (req_ready && !sel_cfg.bus_act) begin
						rsp_valid <= 1'b1;
						rsp       <= {1'b1, 16'h0000};
					end else if (req_ready) begin
						cur_cfg      <= sel_cfg;
						cur_req      <= req;
						ale          <= 1'b1;
						address_port <= req.addr[15:0];
						seg_addr     <= req.addr[23:16];
						cs_n         <= ~(5'(sel_cfg.cs_en) << sel_win);
						cnt          <= sel_cfg.ale_long ? `EBU_ALE_LONG_CNT
							: `EBU_ALE_SHORT_CNT;
						if (sel_cfg.mode == EBU_MODE_8_MUX || sel_cfg.mode == EBU_MODE_16_MUX) begin
							data_port_out <= req.addr[15:0];
							data_oe       <= 1'b1;
						end else begin
							data_oe <= 1'b0;
						end
						state <= EBU_ST_ADDR;
					end
				end
				EBU_ST_ADDR: begin
					if (cnt != 4'h0) begin
						cnt <= cnt - 4'h1;
					end else begin
						ale     <= 1'b0;
						data_oe <= 1'b0;
						if (cur_cfg.rw_delay) begin
							state <= EBU_ST_DELAY;
						end else begin
							rd_n          <= cur_req.write;
							wr_n          <= !cur_req.write;
							data_port_out <= cur_8bit ? {8'h00, cur_req.wdata[7:0]}
								: cur_req.wdata;
							data_oe       <= cur_req.write;
							cnt           <= cur_cfg.wait_cnt;
							state         <= EBU_ST_STROBE;
						end
					end
				end
				EBU_ST_DELAY: begin
					rd_n          <= cur_req.write;
					wr_n          <= !cur_req.write;
					data_port_out <= cur_8bit ? {8'h00, cur_req.wdata[7:0]} : cur_req.wdata;
					data_oe       <= cur_req.write;
					cnt           <= cur_cfg.wait_cnt;
					state         <= EBU_ST_STROBE;
				end
				EBU_ST_STROBE: begin
					if (cnt != 4'h0) begin
						cnt <= cnt - 4'h1;
					end else if (cur_cfg.rdy_en && ready_sync_n) begin
						cnt <= 4'h0;
					end else begin
						rd_n      <= 1'b1;
						wr_n      <= 1'b1;
						data_oe   <= 1'b0;
						rsp_valid <= 1'b1;
						rsp       <= {1'b0, cur_8bit ? {8'h00, sync_data[7:0]} : sync_data};
						if (cur_cfg.tri_extra) begin
							state <= EBU_ST_TRIS;
						end else begin
							cs_n  <= 5'h1f;
							state <= EBU_ST_IDLE;
						end
					end
				end
				EBU_ST_TRIS: begin
					cs_n  <= 5'h1f;
					state <= EBU_ST_IDLE;
				end
				EBU_ST_HELD: begin
					if (hold_sync_n || !hold_en) begin
						state <= EBU_ST_IDLE;
					end
				end
				default: begin
					state <= EBU_ST_IDLE;
				end
			endcase
		end
	end

	// Shared lines float while another master owns the bus
	assign floating = (state == EBU_ST_HELD) || ((state == EBU_ST_IDLE) && !granted);

	assign ctrl_oe         = !floating;
	assign data_port_oe    = {16{data_oe && !floating}};
	assign address_port_oe = !floating && !cur_mux;

	always_comb begin
		case (system_config_reg[`EBU_SYSCFG_SEG_HI:`EBU_SYSCFG_SEG_LO])
			`EBU_SEG_1M:   seg_addr_oe = `EBU_SEGOE_1M;
			`EBU_SEG_256K: seg_addr_oe = `EBU_SEGOE_256K;
			`EBU_SEG_64K:  seg_addr_oe = `EBU_SEGOE_64K;
			default:       seg_addr_oe = `EBU_SEGOE_16M;
		endcase
		if (floating) begin
			seg_addr_oe = 8'h00;
		end
	end

	// Arbitration pins are only taken over once hold is enabled
	assign hold_ack_pin_oe    = hold_en && !slave;
	assign hold_ack_pin_n_out = !(state == EBU_ST_HELD);
	assign bus_request_pin_oe = hold_en;
	assign bus_request_pin_n  = slave ? !(req_valid || state != EBU_ST_IDLE)
		: !((state == EBU_ST_HELD) && req_valid);

endmodule : ebu_external_bus_unit

/* File: verilog/ebu_map.svh */
`ifndef EBU_MAP_SVH
`define EBU_MAP_SVH

// Register indexes on the plain register port
`define EBU_OFF_SYSCFG    8'h00
`define EBU_OFF_PORTDIR   8'h01
`define EBU_OFF_STATUS    8'h02
`define EBU_OFF_BCFG0     8'h08
`define EBU_OFF_WSEL1     8'h11
`define EBU_NUM_WIN       4

// System configuration and port direction fields
`define EBU_SYSCFG_HOLD_ENABLE_BIT  4
`define EBU_SYSCFG_SEG_HI 2
`define EBU_SYSCFG_SEG_LO 1
`define EBU_DIR_ACK_BIT   7

// Segment line enables per address space size
`define EBU_SEG_16M       2'h0
`define EBU_SEG_1M        2'h1
`define EBU_SEG_256K      2'h2
`define EBU_SEG_64K       2'h3
`define EBU_SEGOE_16M     8'hff
`define EBU_SEGOE_1M      8'h0f
`define EBU_SEGOE_256K    8'h03
`define EBU_SEGOE_64K     8'h00

// Reset values
`define EBU_SYSCFG_RST    16'h0000
`define EBU_PORTDIR_RST   16'h0000
`define EBU_BCFG_RST      16'h0000
`define EBU_WSEL_RST      16'h0000

// Timing counts in clock cycles, then the window base mask
`define EBU_ALE_LONG_CNT  4'h1
`define EBU_ALE_SHORT_CNT 4'h0
`define EBU_WIN_BASE_MASK 24'hfff000

`endif

/* File: verilog/ebu_pkg.sv */
package ebu_pkg;

	typedef enum logic [1:0] {
		EBU_MODE_8_DEMUX,
		EBU_MODE_8_MUX,
		EBU_MODE_16_DEMUX,
		EBU_MODE_16_MUX
	} ebu_mode_t;

	typedef struct packed {
		logic [3:0] rsvd;
		logic       cs_en;
		logic       bus_act;
		logic       rdy_en;
		ebu_mode_t  mode;
		logic       rw_delay;
		logic       ale_long;
		logic       tri_extra;
		logic [3:0] wait_cnt;
	} ebu_bus_cfg_t;

	typedef struct packed {
		logic        write;
		logic [23:0] addr;
		logic [15:0] wdata;
	} ebu_req_t;

	typedef struct packed {
		logic        err;
		logic [15:0] rdata;
	} ebu_rsp_t;

	typedef enum logic [2:0] {
		EBU_ST_IDLE,
		EBU_ST_ADDR,
		EBU_ST_DELAY,
		EBU_ST_STROBE,
		EBU_ST_TRIS,
		EBU_ST_HELD
	} ebu_state_t;

endpackage : ebu_pkg

/* File: verilog/ebu_window_match.sv */
`timescale 1ns/10ps
`include "ebu_map.svh"

module ebu_window_match #(
	parameter int ADDR_W = 24
) (
	input  logic [15:0]       window_select_reg,
	input  logic [ADDR_W-1:0] addr,
	output logic              hit
);
	logic [ADDR_W-1:0] base;
	logic [ADDR_W-1:0] mask;

	// Size code doubles the window from 4 KByte upward
	assign base = {window_select_reg[15:4], 12'h000};
	assign mask = `EBU_WIN_BASE_MASK << window_select_reg[3:0];
	assign hit  = ((addr ^ base) & mask) == '0;

endmodule : ebu_window_match
